// [design/p4m_defs.svh]
// constants for the pin 4 output source selector
//
// Overview of operation
// - source 000-011 picks receive port 0-3
// - 100 device status, 101 reserved, 11x transmit
// - receive select 000-011 gives remote pin 0-3
// - receive select 100-111 gives lock, pass, valids
// - status select 000 value, 001 lock, 010 pass
// - status 011 frame sync; selects 100-111 reserved
// - transmit select 000 pass AND, 001 OR
// - transmit select 010 frame, 011 line
// - transmit 100 synced, 101 interrupt, 11x reserved
// - bit 1 holds local drive value
// - bit 0 enables pin output driver
`ifndef P4M_DEFS_SVH
`define P4M_DEFS_SVH

// ****************************************************************
// register addresses
// ****************************************************************
`define P4M_ADDR_CTL     8'h14
`define P4M_ADDR_RXEN    8'h20
`define P4M_ADDR_TX0MAP  8'h21
`define P4M_ADDR_TX1MAP  8'h22
`define P4M_ADDR_STAT    8'h23

// ****************************************************************
// reset values
// ****************************************************************
`define P4M_CTL_RST      8'h00
`define P4M_MASK_RST     4'hf
`define P4M_ZERO8        8'h00

// ****************************************************************
// source codes
// ****************************************************************
`define P4M_SRC_RX0      3'h0
`define P4M_SRC_RX1      3'h1
`define P4M_SRC_RX2      3'h2
`define P4M_SRC_RX3      3'h3
`define P4M_SRC_DEV      3'h4
`define P4M_SRC_RESV     3'h5
`define P4M_SRC_TX0      3'h6
`define P4M_SRC_TX1      3'h7

// ****************************************************************
// select codes
// ****************************************************************
`define P4M_SEL_0        3'h0
`define P4M_SEL_1        3'h1
`define P4M_SEL_2        3'h2
`define P4M_SEL_3        3'h3
`define P4M_SEL_4        3'h4
`define P4M_SEL_5        3'h5
`define P4M_SEL_6        3'h6
`define P4M_SEL_7        3'h7

`endif

// [design/p4m_pkg.sv]
// types for the pin 4 output source selector
package p4m_pkg;

	// ****************************************************************
	// control register layout, bits 7:5 4:2 1 0
	// ****************************************************************
	typedef struct packed {
		logic [2:0] pin4_output_select;
		logic [2:0] pin4_output_source;
		logic       pin4_local_value;
		logic       pin4_drive_enable;
	} p4m_ctl_s;

	// ****************************************************************
	// status of one receive port
	// ****************************************************************
	typedef struct packed {
		logic remote_pin3;
		logic remote_pin2;
		logic remote_pin1;
		logic remote_pin0;
		logic lock;
		logic pass;
		logic frame_valid;
		logic line_valid;
	} p4m_rx_s;

	// ****************************************************************
	// status of one csi-2 transmit port
	// ****************************************************************
	typedef struct packed {
		logic frame_active;
		logic line_active;
		logic synchronized;
		logic interrupt;
	} p4m_tx_s;

	typedef logic [3:0] p4m_mask_t;

endpackage

// [design/p4m_agg.sv]
// masked and/or reduction over the four receive ports
`timescale 1ns/1ns
module p4m_agg (
	input  wire p4m_pkg::p4m_mask_t vec,
	input  wire p4m_pkg::p4m_mask_t mask,
	output logic                    all_and,
	output logic                    any_or
);
	import p4m_pkg::*;

	// empty mask gives 0 for both: no port, no pass
	always_comb begin
		any_or  = |(vec & mask);
		all_and = (|mask) & (&(vec | ~mask));
	end
endmodule // p4m_agg

// [design/p4m_top.sv]
// pin 4 output source selector with its control registers
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`include "p4m_defs.svh"
module p4m_top (
	input  wire                        MCLK,
	input  wire                        RESET_N,
	input  wire  [7:0]                 ADDR,
	input  wire  [7:0]                 WDATA,
	input  wire                        WR,
	input  wire                        RD,
	output logic [7:0]                 RDATA,
	input  wire  p4m_pkg::p4m_rx_s [3:0] RX_STAT,
	input  wire  p4m_pkg::p4m_tx_s [1:0] TX_STAT,
	input  wire                        FRAME_SYNC_PULSE,
	output logic                       PIN4_OUT,
	output logic                       PIN4_OE
);
	import p4m_pkg::*;

	// ****************************************************************
	// declarations
	// ****************************************************************
	p4m_ctl_s  ctl_q;
	p4m_ctl_s  ctl_d;
	p4m_mask_t rxen_q;
	p4m_mask_t rxen_d;
	p4m_mask_t tx0map_q;
	p4m_mask_t tx0map_d;
	p4m_mask_t tx1map_q;
	p4m_mask_t tx1map_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       pin_q;
	logic       pin_d;
	logic       oe_q;
	logic       oe_d;
	logic       resv_q;
	logic       resv_d;
	p4m_mask_t  lock_vec;
	p4m_mask_t  pass_vec;
	logic       dev_lock_or;
	logic       dev_pass_and;
	logic       tx0_and;
	logic       tx0_or;
	logic       tx1_and;
	logic       tx1_or;
	logic       sel_val;
	logic       sel_resv;
	p4m_rx_s    rx_pick;
	p4m_tx_s    tx_pick;
	logic       tx_and;
	logic       tx_or;

	function automatic logic hit(input logic [7:0] a,
	                             input logic [7:0] r);
		hit = (a == r);
	endfunction

	// ****************************************************************
	// register writes
	// ****************************************************************
	always_comb begin
		ctl_d    = ctl_q;
		rxen_d   = rxen_q;
		tx0map_d = tx0map_q;
		tx1map_d = tx1map_q;
		if (WR) begin
			if (hit(ADDR, `P4M_ADDR_CTL)) begin
				ctl_d = p4m_ctl_s'(WDATA);
			end
			if (hit(ADDR, `P4M_ADDR_RXEN)) begin
				rxen_d = WDATA[3:0];
			end
			if (hit(ADDR, `P4M_ADDR_TX0MAP)) begin
				tx0map_d = WDATA[3:0];
			end
			if (hit(ADDR, `P4M_ADDR_TX1MAP)) begin
				tx1map_d = WDATA[3:0];
			end
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctl_q    <= p4m_ctl_s'(`P4M_CTL_RST);
			rxen_q   <= `P4M_MASK_RST;
			tx0map_q <= `P4M_MASK_RST;
			tx1map_q <= `P4M_MASK_RST;
		end else begin
			ctl_q    <= ctl_d;
			rxen_q   <= rxen_d;
			tx0map_q <= tx0map_d;
			tx1map_q <= tx1map_d;
		end
	end

	// ****************************************************************
	// register reads, data only in the cycle after the strobe
	// ****************************************************************
	always_comb begin
		rdata_d = `P4M_ZERO8;
		if (RD) begin
			if (hit(ADDR, `P4M_ADDR_CTL)) begin
				rdata_d = ctl_q;
			end else if (hit(ADDR, `P4M_ADDR_RXEN)) begin
				rdata_d = {4'h0, rxen_q};
			end else if (hit(ADDR, `P4M_ADDR_TX0MAP)) begin
				rdata_d = {4'h0, tx0map_q};
			end else if (hit(ADDR, `P4M_ADDR_TX1MAP)) begin
				rdata_d = {4'h0, tx1map_q};
			end else if (hit(ADDR, `P4M_ADDR_STAT)) begin
				rdata_d = {5'h00, resv_q, oe_q, pin_q};
			end
		end
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_q <= `P4M_ZERO8;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign RDATA = rdata_q;

	// ****************************************************************
	// port aggregation
	// ****************************************************************
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lock_vec[i] = RX_STAT[i].lock;
			pass_vec[i] = RX_STAT[i].pass;
		end
	end

	p4m_agg u_dev_lock (
		.vec     (lock_vec),
		.mask    (rxen_q),
		.all_and (),
		.any_or  (dev_lock_or)
	);

	p4m_agg u_dev_pass (
		.vec     (pass_vec),
		.mask    (rxen_q),
		.all_and (dev_pass_and),
		.any_or  ()
	);

	p4m_agg u_tx0_pass (
		.vec     (pass_vec),
		.mask    (tx0map_q),
		.all_and (tx0_and),
		.any_or  (tx0_or)
	);

	p4m_agg u_tx1_pass (
		.vec     (pass_vec),
		.mask    (tx1map_q),
		.all_and (tx1_and),
		.any_or  (tx1_or)
	);

	// ****************************************************************
	// source and select decode
	// ****************************************************************
	always_comb begin
		rx_pick  = RX_STAT[ctl_q.pin4_output_source[1:0]];
		tx_pick  = TX_STAT[ctl_q.pin4_output_source[0]];
		tx_and   = ctl_q.pin4_output_source[0] ? tx1_and : tx0_and;
		tx_or    = ctl_q.pin4_output_source[0] ? tx1_or : tx0_or;
		sel_val  = 1'b0;
		sel_resv = 1'b0;
		case (ctl_q.pin4_output_source)
			`P4M_SRC_RX0,
			`P4M_SRC_RX1,
			`P4M_SRC_RX2,
			`P4M_SRC_RX3: begin
				case (ctl_q.pin4_output_select)
					`P4M_SEL_0: sel_val = rx_pick.remote_pin0;
					`P4M_SEL_1: sel_val = rx_pick.remote_pin1;
					`P4M_SEL_2: sel_val = rx_pick.remote_pin2;
					`P4M_SEL_3: sel_val = rx_pick.remote_pin3;
					`P4M_SEL_4: sel_val = rx_pick.lock;
					`P4M_SEL_5: sel_val = rx_pick.pass;
					`P4M_SEL_6: sel_val = rx_pick.frame_valid;
					default:    sel_val = rx_pick.line_valid;
				endcase
			end
			`P4M_SRC_DEV: begin
				case (ctl_q.pin4_output_select)
					`P4M_SEL_0: sel_val = ctl_q.pin4_local_value;
					`P4M_SEL_1: sel_val = dev_lock_or;
					`P4M_SEL_2: sel_val = dev_pass_and;
					// frame sync code is printed twice; 011 is the free slot
					`P4M_SEL_3: sel_val = FRAME_SYNC_PULSE;
					default:    sel_resv = 1'b1;
				endcase
			end
			`P4M_SRC_TX0,
			`P4M_SRC_TX1: begin
				case (ctl_q.pin4_output_select)
					`P4M_SEL_0: sel_val = tx_and;
					`P4M_SEL_1: sel_val = tx_or;
					`P4M_SEL_2: sel_val = tx_pick.frame_active;
					`P4M_SEL_3: sel_val = tx_pick.line_active;
					`P4M_SEL_4: sel_val = tx_pick.synchronized;
					`P4M_SEL_5: sel_val = tx_pick.interrupt;
					default:    sel_resv = 1'b1;
				endcase
			end
			default: sel_resv = 1'b1;
		endcase
	end

	// ****************************************************************
	// pin stage
	// ****************************************************************
	// value and enable share one stage so they never skew at the pin
	always_comb begin
		pin_d  = sel_val & ~sel_resv;
		oe_d   = ctl_q.pin4_drive_enable;
		resv_d = sel_resv;
	end

	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pin_q  <= 1'b0;
			oe_q   <= 1'b0;
			resv_q <= 1'b0;
		end else begin
			pin_q  <= pin_d;
			oe_q   <= oe_d;
			resv_q <= resv_d;
		end
	end

	assign PIN4_OUT = pin_q;
	assign PIN4_OE  = oe_q;

endmodule // p4m_top

// [tb/p4m_props.sv]
// checker for the pin 4 output source selector
`timescale 1ns/1ns
`include "p4m_defs.svh"
module p4m_props
	import p4m_pkg::*;
(
	input wire                          MCLK,
	input wire                          RESET_N,
	input wire [7:0]                    ADDR,
	input wire [7:0]                    WDATA,
	input wire                          WR,
	input wire                          RD,
	input wire [7:0]                    RDATA,
	input wire p4m_pkg::p4m_rx_s [3:0]  RX_STAT,
	input wire p4m_pkg::p4m_tx_s [1:0]  TX_STAT,
	input wire                          FRAME_SYNC_PULSE,
	input wire                          PIN4_OUT,
	input wire                          PIN4_OE
);
	// ****
	// shadow registers
	// ****
	logic [7:0] c_q;
	logic [3:0] en_q, m0_q, m1_q, lk, ps, m;
	logic [1:0] arm_q;
	logic [2:0] s, l;
	logic       rxb, dvb, txb;
	// arm skips the first edges, pin flop still settling
	always_ff @(posedge MCLK or negedge RESET_N) begin
		if (!RESET_N) begin
			c_q <= 8'h00;
			en_q <= 4'hf;
			m0_q <= 4'hf;
			m1_q <= 4'hf;
			arm_q <= 2'h0;
		end else begin
			arm_q <= {arm_q[0], 1'b1};
			if (WR && ADDR == `P4M_ADDR_CTL) c_q <= WDATA;
			if (WR && ADDR == `P4M_ADDR_RXEN) en_q <= WDATA[3:0];
			if (WR && ADDR == `P4M_ADDR_TX0MAP) m0_q <= WDATA[3:0];
			if (WR && ADDR == `P4M_ADDR_TX1MAP) m1_q <= WDATA[3:0];
		end
	end
	always_comb begin
		s = c_q[4:2];
		l = c_q[7:5];
		for (int i = 0; i < 4; i++) begin
			lk[i] = RX_STAT[i].lock;
			ps[i] = RX_STAT[i].pass;
		end
		m = s[0] ? m1_q : m0_q;
		rxb = l[2] ? RX_STAT[s[1:0]][3'd7 - l] : RX_STAT[s[1:0]][3'd4 + l];
		case (l)
			3'h0: dvb = c_q[1];
			3'h1: dvb = |(lk & en_q);
			3'h2: dvb = (|en_q) & (&(ps | ~en_q));
			default: dvb = FRAME_SYNC_PULSE;
		endcase
		case (l)
			3'h0: txb = (|m) & (&(ps | ~m));
			3'h1: txb = |(ps & m);
			default: txb = TX_STAT[s[0]][3'd5 - l];
		endcase
	end
	// ****
	// properties
	// ****
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESET_N);
	sequence s_ctl_wr;
		(WR && ADDR == `P4M_ADDR_CTL) ##1 !(WR && ADDR == `P4M_ADDR_CTL);
	endsequence
	AST_RX_PIN: assert property (arm_q[1] && !s[2] && !l[2]
		|=> PIN4_OUT == $past(rxb)) else $error("rx remote pin wrong");
	AST_RX_STAT: assert property (arm_q[1] && !s[2] && l[2]
		|=> PIN4_OUT == $past(rxb)) else $error("rx status wrong");
	AST_DEV: assert property (arm_q[1] && s == 3'h4 && !l[2]
		|=> PIN4_OUT == $past(dvb)) else $error("device status wrong");
	AST_LOCAL: assert property (arm_q[1] && c_q[7:2] == 6'h04
		|=> PIN4_OUT == $past(c_q[1])) else $error("local value wrong");
	AST_TX: assert property (arm_q[1] && s[2:1] == 2'h3 && l < 3'h6
		|=> PIN4_OUT == $past(txb)) else $error("tx status wrong");
	AST_RESV: assert property (arm_q[1] && (s == 3'h5 || (s == 3'h4 && l[2])
		|| (s[2:1] == 2'h3 && l[2:1] == 2'h3)) |=> !PIN4_OUT)
		else $error("reserved code drives pin");
	AST_OE: assert property (s_ctl_wr |=> PIN4_OE == $past(WDATA[0], 2))
		else $error("output enable wrong");
	AST_RD_CTL: assert property (RD && ADDR == `P4M_ADDR_CTL
		|=> RDATA == $past(c_q)) else $error("control readback wrong");
endmodule // p4m_props
bind p4m_top p4m_props u_p4m_props (.MCLK(MCLK), .RESET_N(RESET_N),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.RX_STAT(RX_STAT), .TX_STAT(TX_STAT),
	.FRAME_SYNC_PULSE(FRAME_SYNC_PULSE), .PIN4_OUT(PIN4_OUT),
	.PIN4_OE(PIN4_OE));

// [tb/p4m_pin_sink.sv]
// system logic that senses the pin
`timescale 1ns/1ns
module p4m_pin_sink (
	input  wire  pin_out,
	input  wire  pin_oe,
	output logic level
);
	// released pin falls to its pull-down
	assign level = pin_oe ? pin_out : 1'b0;
endmodule // p4m_pin_sink

// [tb/tb_top.sv]
// self-checking bench for the pin 4 output source selector
`timescale 1ns/1ns
`include "p4m_defs.svh"
module tb_top;
	import p4m_pkg::*;
	logic mclk, rst_n, wr_r, rd_r, fs, pin, oe, lvl, rd_d;
	logic [7:0] addr, wdata, rdata, q[$];
	logic [31:0] v;
	logic [3:0] en, m0, m1;
	logic [1:0] e;
	p4m_rx_s [3:0] rx;
	p4m_tx_s [1:0] tx;
	int n_fail, n_tests, cyc;
	integer seed;
	p4m_top u_p4m_top (.MCLK(mclk), .RESET_N(rst_n), .ADDR(addr),
		.WDATA(wdata), .WR(wr_r), .RD(rd_r), .RDATA(rdata), .RX_STAT(rx),
		.TX_STAT(tx), .FRAME_SYNC_PULSE(fs), .PIN4_OUT(pin), .PIN4_OE(oe));
	p4m_pin_sink u_p4m_pin_sink (.pin_out(pin), .pin_oe(oe), .level(lvl));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// ****
	// tasks
	// ****
	task chk(input logic [7:0] x, input logic [7:0] g, input string nm);
		n_tests++;
		if (g !== x) begin
			n_fail++;
			$display("unexpected %s exp %h got %h", nm, x, g);
		end
	endtask
	task end_sim;
		if (n_fail == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// gap cycle after each strobe keeps one assignment per time step
	task wr(input logic [7:0] a, input logic [7:0] d);
		wr_r <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr_r <= 1'b0;
		@(posedge mclk);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] x);
		q.push_back(x);
		rd_r <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd_r <= 1'b0;
		@(posedge mclk);
	endtask
	// {reserved, pin}
	function logic [1:0] expf(input logic [7:0] c);
		logic [2:0] s, l;
		logic [3:0] lk, ps, m;
		s = c[4:2];
		l = c[7:5];
		for (int i = 0; i < 4; i++) begin
			lk[i] = rx[i].lock;
			ps[i] = rx[i].pass;
		end
		m = s[0] ? m1 : m0;
		if (!s[2]) return {1'b0, l[2] ? rx[s[1:0]][3'd7 - l] : rx[s[1:0]][3'd4 + l]};
		if (s == 3'h5 || l > 3'h5 || (s == 3'h4 && l[2])) return 2'b10;
		if (s == 3'h4) case (l)
			3'h0: return {1'b0, c[1]};
			3'h1: return {1'b0, |(lk & en)};
			3'h2: return {1'b0, (|en) & (&(ps | ~en))};
			default: return {1'b0, fs};
		endcase
		if (l == 3'h0) return {1'b0, (|m) & (&(ps | ~m))};
		if (l == 3'h1) return {1'b0, |(ps & m)};
		return {1'b0, tx[s[0]][3'd5 - l]};
	endfunction
	// ****
	// read data monitor and timeout
	// ****
	always @(posedge mclk) begin
		if (rd_d) chk(q.pop_front(), rdata, "rdata");
		else if (rst_n) chk(8'h00, rdata, "rdata idle");
		rd_d = rd_r;
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		seed = 32'hdc53;
		{rst_n, wr_r, rd_r, fs, rd_d, addr, wdata, rx, tx} = '0;
		{n_fail, n_tests, cyc} = '0;
		{en, m0, m1} = 12'hfff;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rd(`P4M_ADDR_CTL, 8'h00);
		rd(`P4M_ADDR_RXEN, 8'h0f);
		rd(`P4M_ADDR_TX1MAP, 8'h0f);
		wr(8'h30, 8'hff);
		rd(8'h30, 8'h00);
		for (int i = 0; i < 256; i++) begin
			if (i % 16 == 0) begin
				v = $random(seed);
				{en, m0, m1} = v[11:0];
				wr(`P4M_ADDR_RXEN, {v[15:12], en});
				wr(`P4M_ADDR_TX0MAP, {4'h0, m0});
				wr(`P4M_ADDR_TX1MAP, {4'h0, m1});
				rd(`P4M_ADDR_RXEN, {4'h0, en});
			end
			v = $random(seed);
			rx <= v;
			v = $random(seed);
			tx <= v[7:0];
			fs <= v[8];
			wr(`P4M_ADDR_CTL, i[7:0]);
			e = expf(i[7:0]);
			rd(`P4M_ADDR_STAT, {5'h00, e[1], i[0], e[0]});
			chk({7'h00, e[0] & i[0]}, {7'h00, lvl}, "level");
		end
		// mid-run reset clears pin stage and control, sets the masks to 0f
		rst_n <= 1'b0;
		@(posedge mclk);
		chk(8'h00, {5'h00, lvl, oe, pin}, "pins in reset");
		rst_n <= 1'b1;
		rd(`P4M_ADDR_CTL, `P4M_CTL_RST);
		rd(`P4M_ADDR_TX0MAP, 8'h0f);
		// let the last read reach the monitor before the verdict
		repeat (2) @(posedge mclk);
		end_sim();
	end
endmodule // tb_top
